/* design/evcap_top.sv */
// event capture and receive-pin signalling for a CAN system basis chip
// assumes event inputs are one-cycle pulses from the watchdog, supply, mode and serial logic
`timescale 1ns/1ps
`default_nettype none
`include "evcap_defs.svh"

module evcap_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // system mode state
  input wire logic mode_off_i,
  input wire logic mode_reset_i,
  input wire logic mode_overtemp_i,
  input wire logic supply_active_i,
  input wire logic can_offline_i,
  input wire logic bus_active_i,
  // event sources
  input wire logic overtemp_warn_i,
  input wire logic serial_count_err_i,
  input wire logic serial_code_err_i,
  input wire logic serial_locked_wr_i,
  input wire logic wd_overflow_i,
  input wire logic wd_early_i,
  input wire logic wd_window_mode_i,
  input wire logic regulated_supply_low_i,
  input wire logic silence_timeout_i,
  input wire logic can_deact_undervolt_i,
  input wire logic can_deact_txd_clamp_i,
  input wire logic can_wake_i,
  // pins and status
  output logic rxd_o,
  output logic system_reset_out_low_o,
  output logic v1_low_status_o,
  output logic wd_reset_req_o
);
  import evcap_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    hit = (a == ofs);
  endfunction

  wire wr_sys_en = reg_wr_i && hit(reg_addr_i, `EVCAP_OFS_SYS_EN);
  wire wr_sup_en = reg_wr_i && hit(reg_addr_i, `EVCAP_OFS_SUP_EN);
  wire wr_trx_en = reg_wr_i && hit(reg_addr_i, `EVCAP_OFS_TRX_EN);
  wire wr_sys_fl = reg_wr_i && hit(reg_addr_i, `EVCAP_OFS_SYS_FLAGS);
  wire wr_sup_fl = reg_wr_i && hit(reg_addr_i, `EVCAP_OFS_SUP_FLAGS);
  wire wr_trx_fl = reg_wr_i && hit(reg_addr_i, `EVCAP_OFS_TRX_FLAGS);

  ////////////////////////////////////////////////////////////////////////
  // capture enables

  evcap_byte_type sys_en_q;
  evcap_byte_type sup_en_q;
  evcap_byte_type trx_en_q;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sys_en_q <= `EVCAP_RST_EN;
      sup_en_q <= `EVCAP_RST_EN;
      trx_en_q <= `EVCAP_RST_EN;
    end else begin
      if (wr_sys_en) sys_en_q <= reg_wdata_i & `EVCAP_MASK_SYS_EN;
      if (wr_sup_en) sup_en_q <= reg_wdata_i & `EVCAP_MASK_SUP_EN;
      if (wr_trx_en) trx_en_q <= reg_wdata_i & `EVCAP_MASK_TRX_EN;
    end
  end

  wire overtemp_capture_en = sys_en_q[`EVCAP_BIT_OVERTEMP];
  wire serial_fault_capture_en = sys_en_q[`EVCAP_BIT_SERIAL];
  wire undervolt_capture_en = sup_en_q[`EVCAP_BIT_UNDERVOLT];
  wire bus_silence_capture_en = trx_en_q[`EVCAP_BIT_SILENCE];
  wire can_failure_capture_en = trx_en_q[`EVCAP_BIT_CANFAIL];
  wire can_wake_capture_en = trx_en_q[`EVCAP_BIT_CANWAKE];

  ////////////////////////////////////////////////////////////////////////
  // event qualification

  // power-on: leaving Off mode, caught by the registered mode level
  logic off_q;
  logic rst_low_q;
  logic wd_fault_seen;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      off_q <= 1'b1;
    end else begin
      off_q <= mode_off_i;
    end
  end

  wire power_on_evt = off_q && !mode_off_i;
  wire serial_evt = serial_count_err_i || serial_code_err_i || serial_locked_wr_i;
  wire wd_evt = wd_overflow_i || (wd_window_mode_i && wd_early_i);
  // silence armed only once the bus is seen active while the enable is set
  logic silence_armed_q;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      silence_armed_q <= 1'b0;
    end else begin
      silence_armed_q <= bus_silence_capture_en && (bus_active_i || silence_armed_q);
    end
  end
  wire silence_evt = silence_armed_q && silence_timeout_i;
  wire canfail_evt = can_deact_undervolt_i || can_deact_txd_clamp_i || regulated_supply_low_i;
  wire wake_evt = can_wake_i && can_offline_i;
  // undervolt only counts while the regulator is up, any threshold selection
  wire undervolt_evt = regulated_supply_low_i && supply_active_i;

  wire [7:0] sys_set = ({7'h00, power_on_evt} << `EVCAP_BIT_POWER_ON)
                     | ({7'h00, overtemp_warn_i && overtemp_capture_en} << `EVCAP_BIT_OVERTEMP)
                     | ({7'h00, serial_evt && serial_fault_capture_en} << `EVCAP_BIT_SERIAL)
                     | ({7'h00, wd_evt} << `EVCAP_BIT_WATCHDOG);
  wire [7:0] sup_set = {7'h00, undervolt_evt && undervolt_capture_en};
  wire [7:0] trx_set = ({7'h00, silence_evt} << `EVCAP_BIT_SILENCE)
                     | ({7'h00, canfail_evt && can_failure_capture_en} << `EVCAP_BIT_CANFAIL)
                     | ({7'h00, wake_evt && can_wake_capture_en} << `EVCAP_BIT_CANWAKE);

  ////////////////////////////////////////////////////////////////////////
  // flag registers

  evcap_byte_type sys_flags;
  evcap_byte_type sup_flags;
  evcap_byte_type trx_flags;
  logic sys_clr;
  logic sup_clr;
  logic trx_clr;

  evcap_flag_reg u_sys_flags (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .set_i(sys_set),
    .clear_wr_i(wr_sys_fl),
    .clear_data_i(reg_wdata_i),
    .mask_i(`EVCAP_MASK_SYS_FLAGS),
    .flags_o(sys_flags),
    .cleared_o(sys_clr)
  );

  evcap_flag_reg u_sup_flags (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .set_i(sup_set),
    .clear_wr_i(wr_sup_fl),
    .clear_data_i(reg_wdata_i),
    .mask_i(`EVCAP_MASK_SUP_FLAGS),
    .flags_o(sup_flags),
    .cleared_o(sup_clr)
  );

  evcap_flag_reg u_trx_flags (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .set_i(trx_set),
    .clear_wr_i(wr_trx_fl),
    .clear_data_i(reg_wdata_i),
    .mask_i(`EVCAP_MASK_TRX_FLAGS),
    .flags_o(trx_flags),
    .cleared_o(trx_clr)
  );

  wire transceiver_pending = |trx_flags;
  wire supply_pending = |sup_flags;
  wire system_pending = |sys_flags;
  wire any_pending = transceiver_pending || supply_pending || system_pending;
  wire any_cleared = sys_clr || sup_clr || trx_clr;

  ////////////////////////////////////////////////////////////////////////
  // reset output and delay timer

  wire reset_low_d = mode_reset_i || mode_overtemp_i || mode_off_i;
  // pin level in its own flop: edge detector wants the request, the pin its inverse
  logic rst_pin_q;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rst_low_q <= 1'b1;
      rst_pin_q <= 1'b0;
    end else begin
      rst_low_q <= reset_low_d;
      rst_pin_q <= !reset_low_d;
    end
  end
  // falling edge of the pin: internal low-request rising
  wire rst_fall = reset_low_d && !rst_low_q;

  logic timer_run;
  logic timer_exp;
  evcap_delay_timer u_timer (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .start_i(any_cleared),
    .stop_i(rst_fall),
    .running_o(timer_run),
    .expire_o(timer_exp)
  );

  ////////////////////////////////////////////////////////////////////////
  // receive pin

  wire signal_ok = can_offline_i && supply_active_i;
  logic rxd_q;
  logic rxd_d;
  // pin held high while timer runs; new events only show after expiry or a stop by the reset pin falling
  assign rxd_d = any_cleared ? 1'b1 :
                 timer_run ? 1'b1 :
                 !(signal_ok && any_pending);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rxd_q <= 1'b1;
    end else begin
      rxd_q <= rxd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path and status

  evcap_byte_type rdata_d;
  evcap_byte_type rdata_q;
  assign rdata_d = hit(reg_addr_i, `EVCAP_OFS_SYS_EN) ? sys_en_q :
                   hit(reg_addr_i, `EVCAP_OFS_SUP_EN) ? sup_en_q :
                   hit(reg_addr_i, `EVCAP_OFS_TRX_EN) ? trx_en_q :
                   hit(reg_addr_i, `EVCAP_OFS_GLOBAL) ?
                     {5'h00, transceiver_pending, supply_pending, system_pending} :
                   hit(reg_addr_i, `EVCAP_OFS_SYS_FLAGS) ? sys_flags :
                   hit(reg_addr_i, `EVCAP_OFS_SUP_FLAGS) ? sup_flags :
                   hit(reg_addr_i, `EVCAP_OFS_TRX_FLAGS) ? trx_flags : 8'h00;

  // any fault in window mode resets at once; outside it a timeout only with a fault already pending
  assign wd_fault_seen = sys_flags[`EVCAP_BIT_WATCHDOG];
  wire wd_reset_d = wd_evt && (wd_window_mode_i || wd_fault_seen);

  logic v1_low_q;
  logic wd_reset_q;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
      v1_low_q <= 1'b0;
      wd_reset_q <= 1'b0;
    end else begin
      if (reg_rd_i) rdata_q <= rdata_d;
      v1_low_q <= regulated_supply_low_i;
      wd_reset_q <= wd_reset_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign rxd_o = rxd_q;
  assign system_reset_out_low_o = rst_pin_q;
  assign v1_low_status_o = v1_low_q;
  assign wd_reset_req_o = wd_reset_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  // cycles the delay timer has run since its last start, for the length check
  logic [`EVCAP_DELAY_WIDTH-1:0] run_len_q;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || any_cleared || !timer_run) begin
      run_len_q <= '0;
    end else begin
      run_len_q <= run_len_q + `EVCAP_DELAY_WIDTH'(1);
    end
  end

  sequence s_clear_access;
    any_cleared;
  endsequence

  sequence s_expiry_pending;
    timer_exp && !any_cleared && signal_ok && any_pending;
  endsequence

  sequence s_expiry_empty;
    timer_exp && !any_pending;
  endsequence

  a_rxd_release: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    s_clear_access |=> rxd_o) else $error("rxd not released after clear");
  a_rxd_hold_delay: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    timer_run |=> rxd_o) else $error("rxd low while delay runs");
  a_rxd_low_pending: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!timer_run && !any_cleared && signal_ok && any_pending) |=> !rxd_o)
    else $error("rxd not low with pending event");
  a_rxd_high_idle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!any_pending && !timer_run) |=> rxd_o) else $error("rxd low with nothing pending");
  a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (sys_flags[`EVCAP_BIT_WATCHDOG] && !wr_sys_fl) |=> sys_flags[`EVCAP_BIT_WATCHDOG])
    else $error("watchdog flag dropped without clear");
  a_wd_capture: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wd_overflow_i |=> sys_flags[`EVCAP_BIT_WATCHDOG]) else $error("watchdog fault lost");
  a_en_gate: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!overtemp_capture_en && !sys_flags[`EVCAP_BIT_OVERTEMP]) |=> !sys_flags[`EVCAP_BIT_OVERTEMP])
    else $error("overtemp captured while disabled");
  a_timer_stop: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    rst_fall |=> !timer_run) else $error("timer runs after reset fall");
  a_global_sum: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (reg_rd_i && hit(reg_addr_i, `EVCAP_OFS_GLOBAL)) |=>
      reg_rdata_o[2:0] == {$past(transceiver_pending), $past(supply_pending), $past(system_pending)})
    else $error("global summary wrong");
  a_reset_out: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    mode_off_i |=> !system_reset_out_low_o) else $error("reset output not low in off");
  a_delay_length: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    timer_exp |-> run_len_q == `EVCAP_DELAY_CYCLES) else $error("delay timer length wrong");
  a_rxd_expiry_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    s_expiry_pending |=> !rxd_o) else $error("rxd not low at expiry with events pending");
  a_rxd_expiry_high: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    s_expiry_empty |=> rxd_o) else $error("rxd low at expiry with nothing pending");
  a_power_on_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    power_on_evt |=> sys_flags[`EVCAP_BIT_POWER_ON]) else $error("power-on flag not set");
  a_undervolt_gate: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (undervolt_evt && undervolt_capture_en) |=> sup_flags[`EVCAP_BIT_UNDERVOLT])
    else $error("undervolt event lost");
  a_wake_capture: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (wake_evt && can_wake_capture_en) |=> trx_flags[`EVCAP_BIT_CANWAKE]) else $error("wake event lost");
  a_clear_one: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (wr_sys_fl && reg_wdata_i[`EVCAP_BIT_WATCHDOG] && !wd_evt) |=> !sys_flags[`EVCAP_BIT_WATCHDOG])
    else $error("watchdog flag not cleared by one");
  a_v1_status: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    regulated_supply_low_i |=> v1_low_status_o) else $error("v1 low status not set");
endmodule

`default_nettype wire

/* common/evcap_defs.svh */
// event capture block: register offsets, field positions, reset values, timing counts
// assumes inclusion by bare name from package and design files
`ifndef EVCAP_DEFS_SVH
`define EVCAP_DEFS_SVH

// register offsets
`define EVCAP_OFS_SYS_EN      7'h04
`define EVCAP_OFS_SUP_EN      7'h1C
`define EVCAP_OFS_TRX_EN      7'h23
`define EVCAP_OFS_GLOBAL      7'h60
`define EVCAP_OFS_SYS_FLAGS   7'h61
`define EVCAP_OFS_SUP_FLAGS   7'h62
`define EVCAP_OFS_TRX_FLAGS   7'h63

// system event bits
`define EVCAP_BIT_POWER_ON    4
`define EVCAP_BIT_OVERTEMP    2
`define EVCAP_BIT_SERIAL      1
`define EVCAP_BIT_WATCHDOG    0
// supply event bits
`define EVCAP_BIT_UNDERVOLT   0
// transceiver event bits
`define EVCAP_BIT_SILENCE     4
`define EVCAP_BIT_CANFAIL     1
`define EVCAP_BIT_CANWAKE     0
// global summary bits
`define EVCAP_BIT_TRX_PEND    2
`define EVCAP_BIT_SUP_PEND    1
`define EVCAP_BIT_SYS_PEND    0

// writable masks per register
`define EVCAP_MASK_SYS_FLAGS  8'h17
`define EVCAP_MASK_SUP_FLAGS  8'h01
`define EVCAP_MASK_TRX_FLAGS  8'h13
`define EVCAP_MASK_SYS_EN     8'h06
`define EVCAP_MASK_SUP_EN     8'h01
`define EVCAP_MASK_TRX_EN     8'h13

// reset values
`define EVCAP_RST_EN          8'h00
`define EVCAP_RST_FLAGS       8'h00

// event delay time in device clock cycles
`define EVCAP_DELAY_CYCLES    16'd1000
`define EVCAP_DELAY_WIDTH     16

`endif

/* common/evcap_pkg.sv */
// event capture block: shared types
// assumes evcap_defs.svh on the include path
`include "evcap_defs.svh"

package evcap_pkg;
  typedef logic [7:0] evcap_byte_type;
  typedef logic [6:0] evcap_addr_type;
  typedef enum logic [1:0] {
    evcap_pin_idle,
    evcap_pin_alert,
    evcap_pin_delay
  } evcap_pin_state_type;
endpackage

/* design/evcap_flag_reg.sv */
// one write-one-to-clear event flag byte with a fixed bit mask; capture gating is done by the caller
// assumes synchronous reset and one-cycle event and write pulses
`timescale 1ns/1ps
`default_nettype none
`include "evcap_defs.svh"

module evcap_flag_reg (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // events, already qualified by their enables
  input wire logic [7:0] set_i,
  // clear access
  input wire logic clear_wr_i,
  input wire logic [7:0] clear_data_i,
  input wire logic [7:0] mask_i,
  // state
  output logic [7:0] flags_o,
  output logic cleared_o
);
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  wire [7:0] clr_bits = clear_wr_i ? (clear_data_i & mask_i) : 8'h00;

  // set wins over clear in the same cycle
  assign flags_d = ((flags_q & ~clr_bits) | set_i) & mask_i;
  // any set bit hit by a one counts as a clearing
  assign cleared_o = |(clr_bits & flags_q);
  assign flags_o = flags_q;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      flags_q <= `EVCAP_RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end
endmodule

`default_nettype wire

/* design/evcap_delay_timer.sv */
// event delay timer: counts down after a flag is cleared
// assumes start and stop are one-cycle pulses; stop wins
`timescale 1ns/1ps
`default_nettype none
`include "evcap_defs.svh"

module evcap_delay_timer (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // control
  input wire logic start_i,
  input wire logic stop_i,
  // state
  output logic running_o,
  output logic expire_o
);
  logic [`EVCAP_DELAY_WIDTH-1:0] count_q;
  logic [`EVCAP_DELAY_WIDTH-1:0] count_d;
  logic running_q;
  logic expire_q;
  wire last_tick = running_q && (count_q == `EVCAP_DELAY_WIDTH'(1));

  assign count_d = stop_i ? '0 :
                   start_i ? `EVCAP_DELAY_CYCLES :
                   running_q ? count_q - `EVCAP_DELAY_WIDTH'(1) : count_q;
  assign running_o = running_q;
  assign expire_o = expire_q;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      count_q <= '0;
      running_q <= 1'b0;
      expire_q <= 1'b0;
    end else begin
      count_q <= count_d;
      running_q <= !stop_i && (start_i || (running_q && !last_tick));
      expire_q <= !stop_i && !start_i && last_tick;
    end
  end
endmodule

`default_nettype wire

/* test/evcap_host_model.sv */
// host-side model: byte reads and writes on the register port
// assumes its tasks are called one at a time, just after a clock edge
`timescale 1ns/1ps
`default_nettype none

module evcap_host_model (
  // clock
  input wire logic ref_clk_i,
  // register port
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [6:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  import evcap_pkg::*;

  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 7'h00;
    reg_wdata_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////
  // one idle edge after each access, so back-to-back calls never collide
  task automatic write_reg(input evcap_addr_type a, input evcap_byte_type d);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge ref_clk_i);
    #1 reg_wr_o = 1'b0;
    // released data is inverted so a stale byte is never trusted
    reg_wdata_o = ~d;
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic read_reg(input evcap_addr_type a, output evcap_byte_type d);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge ref_clk_i);
    #1 reg_rd_o = 1'b0;
    @(posedge ref_clk_i);
    #1 d = reg_rdata_i;
  endtask

  // clears only what was seen set, so a late event survives
  task automatic clear_seen(input evcap_addr_type a);
    evcap_byte_type d;
    read_reg(a, d);
    write_reg(a, d);
  endtask
endmodule

`default_nettype wire

/* test/evcap_top_tb.sv */
// self-checking bench for the event capture block
// assumes the host model file and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none

module evcap_top_tb;
  import evcap_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i, wr, rd, rxd_o, rst_low, v1_low, wd_req, r;
  logic mode_off, mode_rst, mode_ot, sup_act, offline, bus_act, wd_win;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, se, pe, te, w;
  logic [10:0] ev, e;
  logic [23:0] x;
  logic [6:0] ea [3] = '{7'h04, 7'h1c, 7'h23};
  logic [7:0] em [3] = '{8'h06, 8'h01, 8'h13};
  integer seed, miscompares, n_tests;

  always #2.5 ref_clk_i = ~ref_clk_i;

  evcap_host_model u_host (.ref_clk_i(ref_clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata));

  evcap_top u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .mode_off_i(mode_off),
    .mode_reset_i(mode_rst), .mode_overtemp_i(mode_ot), .supply_active_i(sup_act),
    .can_offline_i(offline), .bus_active_i(bus_act), .overtemp_warn_i(ev[0]),
    .serial_count_err_i(ev[1]), .serial_code_err_i(ev[2]), .serial_locked_wr_i(ev[3]),
    .wd_overflow_i(ev[4]), .wd_early_i(ev[5]), .wd_window_mode_i(wd_win),
    .regulated_supply_low_i(ev[6]), .silence_timeout_i(ev[7]), .can_deact_undervolt_i(ev[8]),
    .can_deact_txd_clamp_i(ev[9]), .can_wake_i(ev[10]), .rxd_o(rxd_o),
    .system_reset_out_low_o(rst_low), .v1_low_status_o(v1_low), .wd_reset_req_o(wd_req));

  ////////////////////////////////////////////////////////////
  // expected flags {transceiver, supply, system} from events and enables
  function automatic logic [23:0] exp_flags(input logic [10:0] e, input logic [7:0] s, p, t,
                                            input logic win);
    // early trigger only counts in window mode
    exp_flags[7:0] = {5'b0, e[0] & s[2], (|e[3:1]) & s[1], e[4] | (e[5] & win)};
    exp_flags[15:8] = {7'b0, e[6] & p[0]};
    exp_flags[23:16] = {3'b0, e[7] & t[4], 2'b0, (e[8] | e[9] | e[6]) & t[1], e[10] & t[0]};
  endfunction

  task automatic tick;
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic check(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_tests++;
    if (got !== ex) begin
      $display("BAD %s expected %h seen %h", nm, ex, got);
      miscompares++;
    end
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] ex);
    logic [7:0] d;
    u_host.read_reg(a, d);
    check($sformatf("reg %h", a), ex, d);
  endtask

  task automatic pulse(input logic [10:0] p);
    ev = p;
    tick;
    ev = 11'h000;
    check("v1 low status", {7'b0, p[6]}, {7'b0, v1_low});
  endtask

  // bounded wait on the receive pin, then compare
  task automatic wait_rxd(input logic v, input int n);
    for (int k = 0; k < n && rxd_o !== v; k++) tick;
    check("rxd", {7'b0, v}, {7'b0, rxd_o});
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // run needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    tally_and_finish;
  end

  initial begin
    seed = 11069;
    miscompares = 0;
    n_tests = 0;
    reset_i = 1'b1;
    ev = 11'h000;
    {mode_off, mode_rst, mode_ot, wd_win} = 4'h0;
    {sup_act, offline, bus_act} = 3'b111;
    repeat (4) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    tick;
    tick;
    rd_chk(7'h61, 8'h10);
    rd_chk(7'h60, 8'h01);
    check("rxd", 8'h00, {7'b0, rxd_o});
    for (int i = 0; i < 3; i++) begin
      rd_chk(ea[i], 8'h00);
      u_host.write_reg(ea[i], 8'hff);
      rd_chk(ea[i], em[i]);
    end
    u_host.write_reg(7'h60, 8'hff);
    rd_chk(7'h60, 8'h01);
    rd_chk(7'h10, 8'h00);
    // clear, event while timer runs, pin low only at expiry
    u_host.write_reg(7'h61, 8'h10);
    check("rxd", 8'h01, {7'b0, rxd_o});
    pulse(11'h010);
    rd_chk(7'h61, 8'h01);
    repeat (950) tick;
    check("rxd", 8'h01, {7'b0, rxd_o});
    wait_rxd(1'b0, 100);
    u_host.write_reg(7'h61, 8'h01);
    repeat (1100) tick;
    check("rxd", 8'h01, {7'b0, rxd_o});
    // reset pin falling stops a running timer
    pulse(11'h010);
    u_host.clear_seen(7'h61);
    pulse(11'h010);
    check("rxd", 8'h01, {7'b0, rxd_o});
    for (int i = 0; i < 3; i++) begin
      {mode_off, mode_rst, mode_ot} = 3'b100 >> i;
      tick;
      tick;
      check("reset pin", 8'h00, {7'b0, rst_low});
      {mode_off, mode_rst, mode_ot} = 3'b000;
      tick;
      tick;
      check("reset pin", 8'h01, {7'b0, rst_low});
    end
    wait_rxd(1'b0, 20);
    rd_chk(7'h61, 8'h11);
    offline = 1'b0;
    wait_rxd(1'b1, 3);
    {offline, sup_act} = 2'b10;
    wait_rxd(1'b1, 3);
    sup_act = 1'b1;
    wait_rxd(1'b0, 3);
    // window failure, timeout with flag clear, timeout with flag set
    for (int i = 0; i < 3; i++) begin
      if (i < 2) u_host.write_reg(7'h61, 8'hff);
      wd_win = (i == 0);
      pulse(i == 0 ? 11'h020 : 11'h010);
      r = wd_req;
      tick;
      r = r | wd_req;
      check("wd reset req", {7'b0, i != 1}, {7'b0, r});
    end
    pulse(11'h080);
    rd_chk(7'h63, 8'h10);
    u_host.write_reg(7'h63, 8'hff);
    u_host.write_reg(7'h23, 8'h00);
    pulse(11'h080);
    rd_chk(7'h63, 8'h00);
    // enable taken while the bus is quiet must not arm silence detection while the bus stays quiet
    bus_act = 1'b0;
    u_host.write_reg(7'h23, 8'h10);
    pulse(11'h080);
    rd_chk(7'h63, 8'h00);
    bus_act = 1'b1;
    for (int i = 0; i < 24; i++) begin
      u_host.write_reg(7'h61, 8'hff);
      u_host.write_reg(7'h62, 8'hff);
      u_host.write_reg(7'h63, 8'hff);
      se = 8'($random(seed));
      pe = 8'($random(seed));
      te = 8'($random(seed));
      e = 11'($random(seed));
      // silence stays out: its arming depends on history, tested above
      e[7] = 1'b0;
      wd_win = 1'($random(seed));
      u_host.write_reg(7'h04, se);
      u_host.write_reg(7'h1c, pe);
      u_host.write_reg(7'h23, te);
      pulse(e);
      x = exp_flags(e, se, pe, te, wd_win);
      rd_chk(7'h61, x[7:0]);
      rd_chk(7'h62, x[15:8]);
      rd_chk(7'h63, x[23:16]);
      rd_chk(7'h60, {5'b0, |x[23:16], |x[15:8], |x[7:0]});
      w = 8'($random(seed));
      u_host.write_reg(7'h61, w);
      rd_chk(7'h61, x[7:0] & ~w);
    end
    tally_and_finish;
  end
endmodule

`default_nettype wire
